/* File: verilog/asq_pkg.sv */
// constants, types and register map of the sample sequencer status and sequencer 1 slice
// assumes one core clock; all users import the whole package
// Functional notes
// - after reset each result queue status register reads 0x100: empty set, full clear, both indices zero.
// - the queue status register shows a read-only full flag in bit 12 and empty flag in bit 8 from live occupancy.
// - bits 7:4 of the queue status show the head index, the slot the next result is written into.
// - bits 3:0 of the queue status show the tail index, the slot the next result-port read returns.
// - sequencer 1 has its own queue status register at 0x06c with the same layout, for its own queue.
// - the sequencer 1 input select register holds four 3-bit fields at 2:0, 6:4, 10:8, 14:12; all else reads zero.
// - while sequencer 1 runs, the select field of sample n picks the input converted for sample n, n = 0 to 3.
// - the sequencer 1 control register holds four 4-bit groups of differential, last, irq-enable and temp bits, reset 0.
// - successive result-port reads return stored results in sample order until the queue is empty.
// - a result stored while the queue is full or a read while it is empty is recorded in overflow or underflow status.
// - each select field names the analog input sampled for its conversion.
// - with a sample's differential bit set the pair numbered by its select field is sampled differentially.
package asq_pkg;

	////////////////////////////////////////////////////////////////////////
	// bus and register map
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] OFS_SEQ_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_OVERFLOW = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_UNDERFLOW = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_SEQ0_RESULT = 8'h48;
	localparam logic [ADDR_W-1:0] OFS_SEQ0_QSTAT = 8'h4c;
	localparam logic [ADDR_W-1:0] OFS_SEQ1_SEL = 8'h60;
	localparam logic [ADDR_W-1:0] OFS_SEQ1_CTL = 8'h64;
	localparam logic [ADDR_W-1:0] OFS_SEQ1_RESULT = 8'h68;
	localparam logic [ADDR_W-1:0] OFS_SEQ1_QSTAT = 8'h6c;

	////////////////////////////////////////////////////////////////////////
	// queue status layout
	localparam int QSTAT_FULL_BIT = 12;
	localparam int QSTAT_EMPTY_BIT = 8;
	localparam int QSTAT_HEAD_LSB = 4;
	localparam int QSTAT_TAIL_LSB = 0;
	localparam int IDX_W = 4;
	localparam logic [DATA_W-1:0] QSTAT_RESET = 32'h0000_0100;

	////////////////////////////////////////////////////////////////////////
	// sequencer 1 configuration layout
	localparam int SEQ1_SAMPLES = 4;
	localparam int CFG_W = 16;
	localparam int SEL_W = 3;
	localparam logic [CFG_W-1:0] SEL_WRITE_MASK = 16'h7777;
	localparam logic [CFG_W-1:0] CFG_RESET = 16'h0000;
	localparam int CTL_DIFF = 0;
	localparam int CTL_LAST = 1;
	localparam int CTL_IRQ_EN = 2;
	localparam int CTL_TEMP = 3;
	localparam int RESULT_W = 10;
	localparam int SEQ0_DEPTH = 8;
	localparam int SEQ1_DEPTH = 4;

	////////////////////////////////////////////////////////////////////////
	// own control, interrupt and error bits
	localparam int CTRL_START = 0;
	localparam int CTRL_BUSY = 1;
	localparam int IRQ_W = 3;
	localparam int IRQ_SAMPLE = 0;
	localparam int IRQ_OVERFLOW = 1;
	localparam int IRQ_UNDERFLOW = 2;
	localparam int ERR_W = 2;
	localparam int ERR_SEQ0 = 0;
	localparam int ERR_SEQ1 = 1;

	////////////////////////////////////////////////////////////////////////
	// types
	typedef struct packed {
		logic [SEL_W-1:0] input_sel;
		logic diff;
		logic temp;
	} asq_conv_type;

	typedef enum logic [2:0] {
		SEQ_IDLE = 3'b001,
		SEQ_ISSUE = 3'b010,
		SEQ_WAIT = 3'b100
	} asq_seq_state_type;

endpackage

/* File: verilog/asq_result_queue.sv */
// result queue: flip-flop storage with head and tail indices and occupancy count
// assumes push and pop come from logic on the same clock
`timescale 1ns/1ps
module asq_result_queue #(
	parameter int DEPTH = 4,
	parameter int DW = 10
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic resetn_i,
	// fill side
	input wire logic push_i,
	input wire logic [DW-1:0] push_data_i,
	// drain side
	input wire logic pop_i,
	output logic [DW-1:0] head_data_o,
	// status
	output logic full_o,
	output logic empty_o,
	output logic [asq_pkg::IDX_W-1:0] head_o,
	output logic [asq_pkg::IDX_W-1:0] tail_o,
	output logic overflow_o,
	output logic underflow_o
);
	import asq_pkg::*;

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [PW:0] DEPTH_CNT = (PW + 1)'(DEPTH);
	localparam logic [PW-1:0] LAST_IDX = PW'(DEPTH - 1);

	logic [DW-1:0] mem_r [DEPTH];
	logic [PW-1:0] head_r;
	logic [PW-1:0] tail_r;
	logic [PW:0] count_r;
	logic do_push;
	logic do_pop;

	// occupancy breaks the tie when head equals tail
	assign full_o = (head_r == tail_r) && (count_r == DEPTH_CNT);
	assign empty_o = (head_r == tail_r) && (count_r == '0);
	// a full queue refuses the result, an empty one the read
	assign do_push = push_i && !full_o;
	assign do_pop = pop_i && !empty_o;
	assign overflow_o = push_i && full_o;
	assign underflow_o = pop_i && empty_o;
	assign head_o = IDX_W'(head_r);
	assign tail_o = IDX_W'(tail_r);
	assign head_data_o = mem_r[tail_r];

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			head_r <= '0;
		end else if (do_push) begin
			head_r <= (head_r == LAST_IDX) ? '0 : head_r + 1'b1;
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tail_r <= '0;
		end else if (do_pop) begin
			tail_r <= (tail_r == LAST_IDX) ? '0 : tail_r + 1'b1;
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			count_r <= '0;
		end else if (do_push && !do_pop) begin
			count_r <= count_r + 1'b1;
		end else if (do_pop && !do_push) begin
			count_r <= count_r - 1'b1;
		end
	end

	generate
		for (genvar e = 0; e < DEPTH; e++) begin : g_entry
			always_ff @(posedge clock_i or negedge resetn_i) begin
				if (!resetn_i) begin
					mem_r[e] <= '0;
				end else if (do_push && head_r == PW'(e)) begin
					mem_r[e] <= push_data_i;
				end
			end
		end
	endgenerate
endmodule

/* File: verilog/asq_seq1_engine.sv */
// sequencer 1 stepper: walks samples 0..3 and asks the converter for one result each
// assumes the converter answers each start with one done pulse on the same clock
`timescale 1ns/1ps
module asq_seq1_engine (
	// clock and reset
	input wire logic clock_i,
	input wire logic resetn_i,
	// configuration
	input wire logic start_i,
	input wire logic [asq_pkg::CFG_W-1:0] sel_i,
	input wire logic [asq_pkg::CFG_W-1:0] ctl_i,
	// converter
	output logic conv_start_o,
	output asq_pkg::asq_conv_type conv_o,
	input wire logic conv_done_i,
	input wire logic [asq_pkg::RESULT_W-1:0] conv_data_i,
	// results
	output logic busy_o,
	output logic push_o,
	output logic [asq_pkg::RESULT_W-1:0] push_data_o,
	output logic sample_irq_o
);
	import asq_pkg::*;

	asq_seq_state_type state_r;
	logic [1:0] idx_r;
	logic [3:0] base;
	logic last_hit;

	assign base = {idx_r, 2'b00};
	// without any last bit the walk still ends after sample 3
	assign last_hit = ctl_i[base + CTL_LAST] || (idx_r == 2'(SEQ1_SAMPLES - 1));
	assign busy_o = (state_r != SEQ_IDLE);

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_r <= SEQ_IDLE;
		end else begin
			unique case (state_r)
				SEQ_IDLE: begin
					if (start_i) begin
						state_r <= SEQ_ISSUE;
					end
				end
				SEQ_ISSUE: begin
					state_r <= SEQ_WAIT;
				end
				SEQ_WAIT: begin
					if (conv_done_i) begin
						state_r <= last_hit ? SEQ_IDLE : SEQ_ISSUE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			idx_r <= '0;
		end else if (state_r == SEQ_IDLE) begin
			idx_r <= '0;
		end else if (state_r == SEQ_WAIT && conv_done_i && !last_hit) begin
			idx_r <= idx_r + 1'b1;
		end
	end

	// the request is latched so the converter sees steady fields while it works
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			conv_o <= '0;
			conv_start_o <= 1'b0;
		end else begin
			conv_start_o <= (state_r == SEQ_ISSUE);
			if (state_r == SEQ_ISSUE) begin
				conv_o.input_sel <= sel_i[base +: SEL_W];
				conv_o.diff <= ctl_i[base + CTL_DIFF];
				conv_o.temp <= ctl_i[base + CTL_TEMP];
			end
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			push_o <= 1'b0;
			push_data_o <= '0;
			sample_irq_o <= 1'b0;
		end else begin
			push_o <= (state_r == SEQ_WAIT) && conv_done_i;
			sample_irq_o <= (state_r == SEQ_WAIT) && conv_done_i && ctl_i[base + CTL_IRQ_EN];
			if (state_r == SEQ_WAIT && conv_done_i) begin
				push_data_o <= conv_data_i;
			end
		end
	end
endmodule

/* File: verilog/asq_top.sv */
// sequencer status and sequencer 1 slice behind a classic wishbone slave
// assumes converter handshake and sequencer 0 results come from logic on clock_i
`timescale 1ns/1ps
module asq_top (
	// clock and reset
	input wire logic clock_i,
	input wire logic resetn_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [asq_pkg::ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [asq_pkg::DATA_W-1:0] wb_dat_i,
	output logic [asq_pkg::DATA_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	// converter
	output logic conv_start_o,
	output asq_pkg::asq_conv_type conv_o,
	input wire logic conv_done_i,
	input wire logic [asq_pkg::RESULT_W-1:0] conv_data_i,
	// sequencer 0 results
	input wire logic seq0_push_i,
	input wire logic [asq_pkg::RESULT_W-1:0] seq0_data_i,
	// interrupt
	output logic irq_o
);
	import asq_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// bus decode

	logic req;
	logic wr;
	logic rd;
	logic [DATA_W-1:0] lane_mask;
	logic [DATA_W-1:0] wdata;

	// ack is given one cycle after the request and never twice in a row
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr = req && wb_we_i;
	assign rd = req && !wb_we_i;
	assign lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign wdata = wb_dat_i & lane_mask;

	////////////////////////////////////////////////////////////////////////
	// address decode, one strobe per register except the two queue status registers

	logic hit_ctrl;
	logic hit_irq_status;
	logic hit_irq_mask;
	logic hit_overflow;
	logic hit_underflow;
	logic hit_seq0_result;
	logic hit_seq1_result;
	logic hit_seq1_sel;
	logic hit_seq1_ctl;

	assign hit_ctrl = (wb_adr_i == OFS_SEQ_CTRL);
	assign hit_irq_status = (wb_adr_i == OFS_IRQ_STATUS);
	assign hit_irq_mask = (wb_adr_i == OFS_IRQ_MASK);
	assign hit_overflow = (wb_adr_i == OFS_OVERFLOW);
	assign hit_underflow = (wb_adr_i == OFS_UNDERFLOW);
	assign hit_seq0_result = (wb_adr_i == OFS_SEQ0_RESULT);
	assign hit_seq1_result = (wb_adr_i == OFS_SEQ1_RESULT);
	assign hit_seq1_sel = (wb_adr_i == OFS_SEQ1_SEL);
	assign hit_seq1_ctl = (wb_adr_i == OFS_SEQ1_CTL);

	////////////////////////////////////////////////////////////////////////
	// configuration registers

	logic [CFG_W-1:0] seq1_input_select_r;
	logic [CFG_W-1:0] seq1_sample_control_r;
	logic [IRQ_W-1:0] irq_mask_r;
	logic start_r;

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			seq1_input_select_r <= CFG_RESET;
		end else if (wr && hit_seq1_sel) begin
			// gaps between the select fields stay zero
			seq1_input_select_r <= ((wdata[CFG_W-1:0] & lane_mask[CFG_W-1:0]) |
				(seq1_input_select_r & ~lane_mask[CFG_W-1:0])) & SEL_WRITE_MASK;
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			seq1_sample_control_r <= CFG_RESET;
		end else if (wr && hit_seq1_ctl) begin
			seq1_sample_control_r <= wdata[CFG_W-1:0] |
				(seq1_sample_control_r & ~lane_mask[CFG_W-1:0]);
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			irq_mask_r <= '0;
		end else if (wr && hit_irq_mask && wb_sel_i[0]) begin
			irq_mask_r <= wdata[IRQ_W-1:0];
		end
	end

	// start is a one-cycle pulse; a write while busy is ignored by the engine
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			start_r <= 1'b0;
		end else begin
			start_r <= wr && hit_ctrl && wdata[CTRL_START];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sequencer 1 engine and the two result queues

	logic busy;
	logic push1;
	logic [RESULT_W-1:0] push1_data;
	logic sample_irq;
	logic pop0;
	logic pop1;
	logic [RESULT_W-1:0] head0_data;
	logic [RESULT_W-1:0] head1_data;
	logic full0;
	logic full1;
	logic empty0;
	logic empty1;
	logic [IDX_W-1:0] head0;
	logic [IDX_W-1:0] head1;
	logic [IDX_W-1:0] tail0;
	logic [IDX_W-1:0] tail1;
	logic ovf0;
	logic ovf1;
	logic unf0;
	logic unf1;
	logic start_go;

	// a start while the walk runs is dropped, not queued
	assign start_go = start_r && !busy;

	asq_seq1_engine u_engine (
		.clock_i(clock_i),
		.resetn_i(resetn_i),
		.start_i(start_go),
		.sel_i(seq1_input_select_r),
		.ctl_i(seq1_sample_control_r),
		.conv_start_o(conv_start_o),
		.conv_o(conv_o),
		.conv_done_i(conv_done_i),
		.conv_data_i(conv_data_i),
		.busy_o(busy),
		.push_o(push1),
		.push_data_o(push1_data),
		.sample_irq_o(sample_irq)
	);

	// a read of the result port takes the head entry and advances the tail
	assign pop0 = rd && hit_seq0_result;
	assign pop1 = rd && hit_seq1_result;

	asq_result_queue #(
		.DEPTH(SEQ0_DEPTH),
		.DW(RESULT_W)
	) u_queue0 (
		.clock_i(clock_i),
		.resetn_i(resetn_i),
		.push_i(seq0_push_i),
		.push_data_i(seq0_data_i),
		.pop_i(pop0),
		.head_data_o(head0_data),
		.full_o(full0),
		.empty_o(empty0),
		.head_o(head0),
		.tail_o(tail0),
		.overflow_o(ovf0),
		.underflow_o(unf0)
	);

	asq_result_queue #(
		.DEPTH(SEQ1_DEPTH),
		.DW(RESULT_W)
	) u_queue1 (
		.clock_i(clock_i),
		.resetn_i(resetn_i),
		.push_i(push1),
		.push_data_i(push1_data),
		.pop_i(pop1),
		.head_data_o(head1_data),
		.full_o(full1),
		.empty_o(empty1),
		.head_o(head1),
		.tail_o(tail1),
		.overflow_o(ovf1),
		.underflow_o(unf1)
	);

	////////////////////////////////////////////////////////////////////////
	// error and interrupt status

	logic [ERR_W-1:0] overflow_status_r;
	logic [ERR_W-1:0] underflow_status_r;
	logic [IRQ_W-1:0] irq_status_r;
	logic [ERR_W-1:0] ovf_set;
	logic [ERR_W-1:0] unf_set;
	logic [IRQ_W-1:0] irq_set;
	logic [ERR_W-1:0] ovf_clr;
	logic [ERR_W-1:0] unf_clr;

	assign ovf_set = {ovf1, ovf0};
	assign unf_set = {unf1, unf0};
	assign irq_set = {|unf_set, |ovf_set, sample_irq};
	assign ovf_clr = (wr && hit_overflow) ? wdata[ERR_W-1:0] : '0;
	assign unf_clr = (wr && hit_underflow) ? wdata[ERR_W-1:0] : '0;

	// write one to clear; an event in the same cycle keeps its bit set
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			overflow_status_r <= '0;
		end else begin
			overflow_status_r <= (overflow_status_r & ~ovf_clr) | ovf_set;
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			underflow_status_r <= '0;
		end else begin
			underflow_status_r <= (underflow_status_r & ~unf_clr) | unf_set;
		end
	end

	// read of the status register clears it, set wins over the clear
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			irq_status_r <= '0;
		end else if (rd && hit_irq_status) begin
			irq_status_r <= irq_set;
		end else begin
			irq_status_r <= irq_status_r | irq_set;
		end
	end

	logic irq_pending;

	// registered so the pin does not glitch while status and mask settle
	assign irq_pending = |(irq_status_r & irq_mask_r);

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= irq_pending;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read mux

	function automatic logic [DATA_W-1:0] qstat(input logic full, input logic empty,
		input logic [IDX_W-1:0] head, input logic [IDX_W-1:0] tail);
		logic [DATA_W-1:0] v;
		v = '0;
		v[QSTAT_FULL_BIT] = full;
		v[QSTAT_EMPTY_BIT] = empty;
		v[QSTAT_HEAD_LSB +: IDX_W] = head;
		v[QSTAT_TAIL_LSB +: IDX_W] = tail;
		return v;
	endfunction

	logic [DATA_W-1:0] qstat0;
	logic [DATA_W-1:0] qstat1;
	logic [DATA_W-1:0] result0;
	logic [DATA_W-1:0] result1;

	assign qstat0 = qstat(full0, empty0, head0, tail0);
	assign qstat1 = qstat(full1, empty1, head1, tail1);
	// an empty queue reads as zero rather than a stale slot
	assign result0 = empty0 ? '0 : DATA_W'(head0_data);
	assign result1 = empty1 ? '0 : DATA_W'(head1_data);

	logic [DATA_W-1:0] rdata;

	always_comb begin
		rdata = '0;
		unique case (wb_adr_i)
			OFS_SEQ_CTRL: rdata[CTRL_BUSY] = busy;
			OFS_IRQ_STATUS: rdata[IRQ_W-1:0] = irq_status_r;
			OFS_IRQ_MASK: rdata[IRQ_W-1:0] = irq_mask_r;
			OFS_OVERFLOW: rdata[ERR_W-1:0] = overflow_status_r;
			OFS_UNDERFLOW: rdata[ERR_W-1:0] = underflow_status_r;
			OFS_SEQ0_RESULT: rdata = result0;
			OFS_SEQ0_QSTAT: rdata = qstat0;
			OFS_SEQ1_SEL: rdata[CFG_W-1:0] = seq1_input_select_r;
			OFS_SEQ1_CTL: rdata[CFG_W-1:0] = seq1_sample_control_r;
			OFS_SEQ1_RESULT: rdata = result1;
			OFS_SEQ1_QSTAT: rdata = qstat1;
			default: rdata = '0;
		endcase
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= req;
			wb_dat_o <= rd ? rdata : '0;
		end
	end
endmodule

/* File: tb/asq_props.sv */
// concurrent checks on the ports of asq_top
// assumes one clock domain, bound from the bench top file
`timescale 1ns/1ps
module asq_props (
	// clock and reset
	input wire logic clock_i,
	input wire logic resetn_i,
	// wishbone
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [asq_pkg::ADDR_W-1:0] wb_adr_i,
	input wire logic [asq_pkg::DATA_W-1:0] wb_dat_o,
	input wire logic wb_ack_o,
	// converter
	input wire logic conv_start_o,
	input wire asq_pkg::asq_conv_type conv_o
);
	import asq_pkg::*;
	logic take;
	logic rd_q;
	assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign rd_q = take && !wb_we_i && (wb_adr_i == OFS_SEQ0_QSTAT || wb_adr_i == OFS_SEQ1_QSTAT);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!resetn_i);
	////////////////////////////////////////////////////////////////////////
	property p_ack_next; take |=> wb_ack_o; endproperty
	a_ack_next: assert property (p_ack_next) else $error("ack not one cycle after request");
	property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	property p_wr_zero; take && wb_we_i |=> wb_dat_o == 32'h0; endproperty
	a_wr_zero: assert property (p_wr_zero) else $error("read data not zero on write");
	property p_qstat_rsv; rd_q |=> wb_dat_o[31:13] == 19'h0 && wb_dat_o[11:9] == 3'h0; endproperty
	a_qstat_rsv: assert property (p_qstat_rsv) else $error("status reserved bits set");
	property p_flags; rd_q |=> !(wb_dat_o[12] && wb_dat_o[8]) && (!(wb_dat_o[12] || wb_dat_o[8])
		|| wb_dat_o[7:4] == wb_dat_o[3:0]); endproperty
	a_flags: assert property (p_flags) else $error("flags disagree with indices");
	property p_idx1; take && !wb_we_i && wb_adr_i == OFS_SEQ1_QSTAT |=> wb_dat_o[7:4] < 4'h4
		&& wb_dat_o[3:0] < 4'h4; endproperty
	a_idx1: assert property (p_idx1) else $error("queue index beyond depth");
	property p_sel_rsv; take && !wb_we_i && wb_adr_i == OFS_SEQ1_SEL |=> (wb_dat_o & ~32'h7777) == 32'h0;
	endproperty
	a_sel_rsv: assert property (p_sel_rsv) else $error("select reserved bits set");
	property p_ctl_rsv; take && !wb_we_i && wb_adr_i == OFS_SEQ1_CTL |=> wb_dat_o[31:16] == 16'h0; endproperty
	a_ctl_rsv: assert property (p_ctl_rsv) else $error("control upper bits set");
	property p_start_pulse; conv_start_o |=> !conv_start_o; endproperty
	a_start_pulse: assert property (p_start_pulse) else $error("start longer than one cycle");
	property p_conv_hold; !conv_start_o |-> $stable(conv_o); endproperty
	a_conv_hold: assert property (p_conv_hold) else $error("conversion setting moved");
	c_pop: cover property (take && wb_adr_i == OFS_SEQ1_RESULT);
	c_start: cover property (conv_start_o ##1 !conv_start_o);
	c_full: cover property (rd_q ##1 wb_dat_o[12]);
endmodule

/* File: tb/tb.sv */
// bench for asq_top: wishbone master, converter responder, sequencer 0 feed
// assumes the design files compile ahead of this one
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
	import asq_pkg::*;
	logic clock_i = 1'b0, resetn_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h0;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, seed = 32'h17, rv, rc, s, c;
	logic wb_ack_o, conv_start_o, irq_o, conv_done_i = 1'b0, seq0_push_i = 1'b0;
	logic [3:0] wb_sel_i = 4'hf, sel_n = 4'hf;
	logic [9:0] conv_data_i = 10'h0, seq0_data_i = 10'h0;
	asq_conv_type conv_o;
	asq_conv_type cq[$];
	logic [9:0] dq[$];
	logic [9:0] q0[$];
	int n_errors = 0, comparisons = 0, t1 = 0;
	always #4 clock_i = ~clock_i;
	asq_top DUT (.clock_i(clock_i), .resetn_i(resetn_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .conv_start_o(conv_start_o), .conv_o(conv_o), .conv_done_i(conv_done_i),
		.conv_data_i(conv_data_i), .seq0_push_i(seq0_push_i), .seq0_data_i(seq0_data_i), .irq_o(irq_o));
	function logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function int nsamp(input logic [31:0] k);
		for (int i = 0; i < 4; i++) if (k[4*i+CTL_LAST]) return i + 1;
		return 4;
	endfunction
	function asq_conv_type econv(input logic [31:0] sl, input logic [31:0] k, input int i);
		econv.input_sel = sl[4*i+:3];
		econv.diff = k[4*i+CTL_DIFF];
		econv.temp = k[4*i+CTL_TEMP];
	endfunction
	function logic [31:0] qstat(input int h, input int t, input int n, input int dep);
		qstat = 32'h0;
		qstat[12] = (n == dep);
		qstat[8] = (n == 0);
		qstat[7:4] = h[3:0];
		qstat[3:0] = t[3:0];
	endfunction
	////////////////////////////////////////////////////////////////////////
	// converter answers every start with a done pulse one cycle later
	always @(posedge clock_i) begin
		conv_done_i <= conv_start_o;
		if (conv_start_o === 1'b1) begin
			rc = xs();
			conv_data_i <= rc[9:0];
			cq.push_back(conv_o);
			dq.push_back(rc[9:0]);
		end
	end
	task summarize();
		$display("n_errors=%0d comparisons=%0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// the request stands until the edge at which ack is sampled high; read data is taken at that same edge
	task wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clock_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_sel_i <= sel_n;
		wb_dat_i <= d;
		repeat (50) begin
			@(posedge clock_i);
			if (wb_ack_o === 1'b1) break;
		end
		if (wb_ack_o !== 1'b1) begin
			n_errors++;
			summarize();
		end
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		`CHK(q, e)
	endtask
	task run(input logic [31:0] sl, input logic [31:0] k);
		cq.delete();
		wr(OFS_SEQ1_SEL, sl);
		wr(OFS_SEQ1_CTL, k);
		wr(OFS_SEQ_CTRL, 32'h1);
		rdc(OFS_SEQ_CTRL, 32'h1 << CTRL_BUSY);
		repeat (200) begin
			@(negedge clock_i);
			if (cq.size() >= nsamp(k)) break;
		end
		repeat (8) @(negedge clock_i);
		`CHK(cq.size(), nsamp(k))
		rdc(OFS_SEQ_CTRL, 32'h0);
		for (int i = 0; i < nsamp(k); i++) `CHK(cq[i], econv(sl, k, i))
	endtask
	task reset_dut();
		resetn_i <= 1'b0;
		repeat (2) @(posedge clock_i);
		resetn_i <= 1'b1;
		rdc(OFS_SEQ0_QSTAT, QSTAT_RESET);
		rdc(OFS_SEQ1_QSTAT, QSTAT_RESET);
		rdc(OFS_SEQ1_SEL, 32'h0);
		rdc(OFS_SEQ1_CTL, 32'h0);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		reset_dut();
		wr(8'hf0, 32'hffffffff);
		rdc(8'hf0, 32'h0);
		// last-sample bit placed at each position in turn, earlier ones cleared
		for (int k = 0; k < 4; k++) begin
			s = xs();
			rv = xs();
			c = {rv[31:16], (rv[15:0] & 16'hdddd) | (16'h2 << (4 * k))};
			run(s, c);
			rdc(OFS_SEQ1_SEL, {16'h0, s[15:0] & SEL_WRITE_MASK});
			rdc(OFS_SEQ1_CTL, {16'h0, c[15:0]});
			rdc(OFS_SEQ1_QSTAT, qstat((t1 + k + 1) % 4, t1, k + 1, 4));
			for (int i = 0; i <= k; i++) rdc(OFS_SEQ1_RESULT, {22'h0, dq.pop_front()});
			t1 = (t1 + k + 1) % 4;
			rdc(OFS_SEQ1_QSTAT, qstat(t1, t1, 0, 4));
			rdc(OFS_SEQ1_RESULT, 32'h0);
			rdc(OFS_UNDERFLOW, 32'h2);
			wr(OFS_UNDERFLOW, 32'h2);
			rdc(OFS_UNDERFLOW, 32'h0);
		end
		// a second full sequence lands on a full queue and must be dropped
		run(xs(), 32'h0);
		run(xs(), 32'h0);
		rdc(OFS_OVERFLOW, 32'h2);
		rdc(OFS_SEQ1_QSTAT, qstat(t1, t1, 4, 4));
		for (int i = 0; i < 4; i++) rdc(OFS_SEQ1_RESULT, {22'h0, dq.pop_front()});
		dq.delete();
		for (int i = 0; i < 9; i++) begin
			@(posedge clock_i);
			rv = xs();
			seq0_push_i <= 1'b1;
			seq0_data_i <= rv[9:0];
			if (i < 8) q0.push_back(rv[9:0]);
		end
		@(posedge clock_i);
		seq0_push_i <= 1'b0;
		rdc(OFS_SEQ0_QSTAT, 32'h1000);
		rdc(OFS_OVERFLOW, 32'h3);
		for (int i = 0; i < 8; i++) rdc(OFS_SEQ0_RESULT, {22'h0, q0[i]});
		rdc(OFS_SEQ0_QSTAT, 32'h100);
		wr(OFS_OVERFLOW, 32'h3);
		// sample interrupt held back by the mask, then let through, then cleared by reading
		wr(OFS_IRQ_MASK, 32'h0);
		wb(1'b0, OFS_IRQ_STATUS, 32'h0, rv);
		run(32'h0, 32'h6);
		`CHK(irq_o, 1'b0)
		wr(OFS_IRQ_MASK, 32'h1);
		repeat (3) @(negedge clock_i);
		`CHK(irq_o, 1'b1)
		rdc(OFS_IRQ_STATUS, 32'h1);
		repeat (3) @(negedge clock_i);
		`CHK(irq_o, 1'b0)
		rdc(OFS_SEQ1_RESULT, {22'h0, dq.pop_front()});
		wr(OFS_SEQ1_CTL, 32'hffff);
		// only the enabled byte lane may change
		sel_n = 4'h1;
		wr(OFS_SEQ1_CTL, 32'h0);
		wr(OFS_SEQ1_SEL, 32'h7777);
		sel_n = 4'hf;
		rdc(OFS_SEQ1_CTL, 32'hff00);
		rdc(OFS_SEQ1_SEL, 32'h0077);
		@(posedge clock_i);
		reset_dut();
		summarize();
	end
endmodule
bind asq_top asq_props u_props (.clock_i(clock_i), .resetn_i(resetn_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .conv_start_o(conv_start_o), .conv_o(conv_o));
